// >>> bsp_pkg.sv
/*
  Constants shared by the beamformer serial register port: the register map,
  the configuration fields, the serial frame bit positions and the defaults.
  Assumes a 15-bit register address space and 8-bit serial data.
*/
`default_nettype none
package bsp_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int WORD_W = 16;
  localparam logic [14:0] ADDR_CFG = 15'h0000;
  localparam logic [14:0] ADDR_BSEL = 15'h0008;
  localparam logic [14:0] WIDE_BASE = 15'h0010;
  localparam logic [14:0] SRAM_BASE = 15'h0100;
  localparam int CFG_SOFT_RST_BIT = 7;
  localparam int CFG_LSB_FIRST_BIT = 6;
  localparam int CFG_ASCEND_BIT = 5;
  localparam int CFG_4WIRE_BIT = 4;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] BSEL_RST = 8'h00;
  localparam logic [1:0] BSEL_LO = 2'h1;
  localparam logic [1:0] BSEL_HI = 2'h2;
  localparam logic [4:0] CNT_DIR = 5'h00;
  localparam logic [4:0] CNT_ADDR_END = 5'h0F;
  localparam logic [4:0] CNT_DATA_BEG = 5'h10;
  localparam logic [4:0] CNT_DATA_END = 5'h17;
  localparam logic [1:0] LOAD_TOGGLES = 2'h3;
  localparam int SDO_DELAY_NS = 7;
endpackage : bsp_pkg
`default_nettype wire

// >>> bsp_spi_port.sv
/*
  Serial register port of the beamformer: shift logic on the serial clock,
  a byte mirror for readback, and the register copies that steer the chip on
  the system clock. Assumes a host that keeps chip select low for a frame and
  lets the serial clock stand still outside frames.
*/
`default_nettype none
module bsp_spi_port #(
  parameter int NWIDE = 4,
  parameter int SRAM_DEPTH = 16,
  parameter int SRAM_GLOBAL = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic load,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe,
  output logic sdo,
  output logic [bsp_pkg::DATA_W-1:0] cfg_q,
  output logic [bsp_pkg::DATA_W-1:0] bsel_q,
  output logic soft_rst_q,
  output wire logic [NWIDE*bsp_pkg::WORD_W-1:0] wide_q
);
  import bsp_pkg::*;

  localparam int WI_W = $clog2(NWIDE);
  localparam int SI_W = $clog2(SRAM_DEPTH);
  localparam logic [14:0] NWIDE_A = 15'(NWIDE);
  localparam logic [14:0] SDEP_A = 15'(SRAM_DEPTH);
  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = v[7-i];
    end
    return r;
  endfunction : rev8

  function automatic logic [14:0] rev15(input logic [14:0] v);
    logic [14:0] r;
    r = '0;
    for (int i = 0; i < 15; i++)
    begin
      r[i] = v[14-i];
    end
    return r;
  endfunction : rev15

  // serial clock domain
  logic [4:0] cnt_r;
  logic rd_r;
  logic [14:0] sh_r;
  logic [14:0] addr_r;
  logic hr_s1_r, hr_s2_r, hack_r;
  logic [7:0] cfg_m, bsel_m, sram_q_r;
  logic [15:0] wide_m [NWIDE];
  logic [7:0] sram_m [SRAM_DEPTH];
  logic wr_tgl_r;
  logic [14:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic [7:0] osh_r;
  // system clock domain
  logic hreq_r;
  logic ws1_r, ws2_r, ws3_r;
  logic ha1_r, ha2_r;
  logic ls1_r, ls2_r, ls3_r, lf_r;
  logic [1:0] ld_cnt_r;
  logic [15:0] wide_pend_r [NWIDE];
  logic [15:0] wide_act_r [NWIDE];

  logic lsb_first, ascend;
  logic [14:0] addr_in, wide_off, sram_off;
  logic [7:0] din, rd_byte, rd_send;
  logic is_wide, is_sram, wr_ev, rd_ev;

  assign lsb_first = cfg_m[CFG_LSB_FIRST_BIT];
  assign ascend = cfg_m[CFG_ASCEND_BIT];
  assign addr_in = lsb_first ? rev15({sh_r[13:0], sdio_i}) : {sh_r[13:0], sdio_i};
  assign din = lsb_first ? rev8({sh_r[6:0], sdio_i}) : {sh_r[6:0], sdio_i};
  assign wide_off = addr_r - WIDE_BASE;
  assign sram_off = addr_r - SRAM_BASE;
  assign is_wide = (addr_r >= WIDE_BASE) && (wide_off < NWIDE_A);
  assign is_sram = (addr_r >= SRAM_BASE) && (sram_off < SDEP_A);
  assign wr_ev = (cnt_r == CNT_DATA_END) && !rd_r;
  assign rd_ev = (cnt_r == CNT_DATA_END) && rd_r;

  // frame sequencing; chip select high clears it
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      cnt_r <= CNT_DIR;
      rd_r <= 1'b0;
      sh_r <= '0;
      addr_r <= '0;
      hr_s1_r <= 1'b0;
      hr_s2_r <= 1'b0;
      hack_r <= 1'b0;
    end
    else
    begin
      hr_s1_r <= hreq_r;
      hr_s2_r <= hr_s1_r;
      hack_r <= hr_s2_r;
      sh_r <= {sh_r[13:0], sdio_i};
      if (cnt_r == CNT_DIR)
      begin
        rd_r <= sdio_i;
      end
      if (cnt_r == CNT_DATA_END)
      begin
        cnt_r <= CNT_DATA_BEG;
      end
      else
      begin
        cnt_r <= cnt_r + 5'h01;
      end
      if (cnt_r == CNT_ADDR_END)
      begin
        addr_r <= addr_in;
      end
      else if (cnt_r == CNT_DATA_END)
      begin
        addr_r <= ascend ? addr_r + 15'h0001 : addr_r - 15'h0001;
      end
    end
  end

  // readback mirror and write forwarding
  always_ff @(posedge sclk)
  begin
    if (hr_s2_r)
    begin
      cfg_m <= CFG_RST;
      bsel_m <= BSEL_RST;
      wr_tgl_r <= 1'b0;
      for (int i = 0; i < NWIDE; i++)
      begin
        wide_m[i] <= '0;
      end
      for (int i = 0; i < SRAM_GLOBAL; i++)
      begin
        sram_m[i] <= '0;
      end
    end
    else if (wr_ev)
    begin
      wr_tgl_r <= ~wr_tgl_r;
      wr_addr_r <= addr_r;
      wr_data_r <= din;
      if (addr_r == ADDR_CFG)
      begin
        if (din[CFG_SOFT_RST_BIT])
        begin
          cfg_m <= CFG_RST;
          bsel_m <= BSEL_RST;
          for (int i = 0; i < NWIDE; i++)
          begin
            wide_m[i] <= '0;
          end
        end
        else
        begin
          cfg_m <= din;
        end
      end
      else if (addr_r == ADDR_BSEL)
      begin
        bsel_m <= din;
      end
      else if (is_wide && bsel_m[1:0] == BSEL_LO)
      begin
        wide_m[wide_off[WI_W-1:0]][7:0] <= din;
      end
      else if (is_wide && bsel_m[1:0] == BSEL_HI)
      begin
        wide_m[wide_off[WI_W-1:0]][15:8] <= din;
      end
      else if (is_sram)
      begin
        sram_m[sram_off[SI_W-1:0]] <= din;
      end
    end
    // the sram latch is refreshed only after a read has sent the old value
    if (rd_ev && is_sram)
    begin
      sram_q_r <= sram_m[sram_off[SI_W-1:0]];
    end
  end

  always_comb
  begin
    rd_byte = '0;
    if (addr_r == ADDR_CFG)
    begin
      rd_byte = cfg_m;
    end
    else if (addr_r == ADDR_BSEL)
    begin
      rd_byte = bsel_m;
    end
    else if (is_wide)
    begin
      rd_byte = (bsel_m[1:0] == BSEL_HI) ? wide_m[wide_off[WI_W-1:0]][15:8]
                                         : wide_m[wide_off[WI_W-1:0]][7:0];
    end
    else if (is_sram)
    begin
      rd_byte = sram_q_r;
    end
    rd_send = lsb_first ? rev8(rd_byte) : rd_byte;
  end

  // read data leaves on falling edges from the 16th on
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      sdo <= 1'b0;
      sdio_o <= 1'b0;
      sdio_oe <= 1'b0;
      osh_r <= '0;
    end
    else if (rd_r && cnt_r == CNT_DATA_BEG)
    begin
      sdo <= rd_send[7];
      sdio_o <= rd_send[7];
      sdio_oe <= !cfg_m[CFG_4WIRE_BIT];
      osh_r <= {rd_send[6:0], 1'b0};
    end
    else if (rd_r)
    begin
      sdo <= osh_r[7];
      sdio_o <= osh_r[7];
      osh_r <= {osh_r[6:0], 1'b0};
    end
  end

  // hard reset request held until the serial side has applied it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hreq_r <= 1'b1;
      ha1_r <= 1'b0;
      ha2_r <= 1'b0;
    end
    else if (ce)
    begin
      ha1_r <= hack_r;
      ha2_r <= ha1_r;
      if (ha2_r)
      begin
        hreq_r <= 1'b0;
      end
    end
  end

  // write event and load pin synchronisers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ws1_r <= 1'b0;
      ws2_r <= 1'b0;
      ws3_r <= 1'b0;
      ls1_r <= 1'b0;
      ls2_r <= 1'b0;
      ls3_r <= 1'b0;
    end
    else if (ce)
    begin
      // the serial toggle is unknown until the first frame clears it
      ws1_r <= wr_tgl_r && !hreq_r;
      ws2_r <= ws1_r;
      ws3_r <= ws2_r;
      ls1_r <= load;
      ls2_r <= ls1_r;
      ls3_r <= ls2_r;
    end
  end

  logic wr_c, soft_c, load_tog, load_fire;
  assign wr_c = ws2_r ^ ws3_r;
  assign soft_c = wr_c && wr_addr_r == ADDR_CFG && wr_data_r[CFG_SOFT_RST_BIT];
  assign load_tog = (ls2_r == ls3_r) && (ls3_r != lf_r);
  assign load_fire = load_tog && (ld_cnt_r == LOAD_TOGGLES - 2'h1);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lf_r <= 1'b0;
      ld_cnt_r <= '0;
    end
    else if (ce && load_tog)
    begin
      lf_r <= ls3_r;
      ld_cnt_r <= load_fire ? 2'h0 : ld_cnt_r + 2'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfg_q <= CFG_RST;
      bsel_q <= BSEL_RST;
      soft_rst_q <= 1'b0;
    end
    else if (ce)
    begin
      soft_rst_q <= soft_c;
      if (soft_c)
      begin
        cfg_q <= CFG_RST;
        bsel_q <= BSEL_RST;
      end
      else if (wr_c && wr_addr_r == ADDR_CFG)
      begin
        cfg_q <= wr_data_r;
      end
      else if (wr_c && wr_addr_r == ADDR_BSEL)
      begin
        bsel_q <= wr_data_r;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NWIDE; g++)
    begin : g_wide
      localparam logic [14:0] WADDR = WIDE_BASE + 15'(g);
      logic hit;
      assign hit = wr_c && wr_addr_r == WADDR;
      always_ff @(posedge clk)
      begin
        if (rst || (ce && soft_c))
        begin
          wide_pend_r[g] <= '0;
          wide_act_r[g] <= '0;
        end
        else if (ce)
        begin
          if (hit && bsel_q[1:0] == BSEL_LO)
          begin
            wide_pend_r[g][7:0] <= wr_data_r;
          end
          else if (hit && bsel_q[1:0] == BSEL_HI)
          begin
            wide_pend_r[g][15:8] <= wr_data_r;
          end
          if (load_fire)
          begin
            wide_act_r[g] <= wide_pend_r[g];
          end
        end
      end
      assign wide_q[g*WORD_W +: WORD_W] = wide_act_r[g];
    end
  endgenerate
endmodule : bsp_spi_port
`default_nettype wire

// >>> bsp_port_properties.sv
/*
  Checker of the serial register port, bound to bsp_spi_port.
  Sees only the ports of that module.
*/
`default_nettype none
module bsp_port_chk
  import bsp_pkg::*;
#(
  parameter int NWIDE = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic load,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdio_i,
  input wire logic sdio_o,
  input wire logic sdio_oe,
  input wire logic sdo,
  input wire logic [DATA_W-1:0] cfg_q,
  input wire logic [DATA_W-1:0] bsel_q,
  input wire logic soft_rst_q,
  input wire logic [NWIDE*WORD_W-1:0] wide_q
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] cnt_r;
  logic rd_r;
  logic load_r;
  logic [3:0] quiet_r;
  // rising serial edges in this frame
  always_ff @(posedge sclk or posedge cs_n)
    if (cs_n)
      cnt_r <= 5'h00;
    else if (cnt_r != 5'h1F)
      cnt_r <= cnt_r + 5'h01;
  always_ff @(posedge sclk)
    if (cnt_r == 5'h00)
      rd_r <= sdio_i;
  always_ff @(posedge clk)
    load_r <= load;
  // cycles since a load edge or a reset
  always_ff @(posedge clk)
    if (rst || soft_rst_q || load != load_r)
      quiet_r <= 4'h0;
    else if (quiet_r != 4'hF)
      quiet_r <= quiet_r + 4'h1;
  property p_rst;
    @(posedge clk) rst && ce |=> cfg_q == CFG_RST && bsel_q == BSEL_RST && wide_q == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values");
  property p_soft;
    @(posedge clk) disable iff (rst)
      soft_rst_q |=> !soft_rst_q ##[0:3] (cfg_q == CFG_RST && wide_q == '0);
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset");
  property p_quiet;
    @(posedge clk) disable iff (rst) quiet_r == 4'hF && !soft_rst_q |-> $stable(wide_q);
  endproperty
  a_quiet: assert property (p_quiet) else $error("wide changed without load");
  property p_idle;
    @(posedge clk) disable iff (rst) cs_n |-> !sdio_oe;
  endproperty
  a_idle: assert property (p_idle) else $error("driving while deselected");
  property p_oe_early;
    @(posedge sclk) disable iff (cs_n) cnt_r < 5'h10 |-> !sdio_oe;
  endproperty
  a_oe_early: assert property (p_oe_early) else $error("drive before data phase");
  property p_oe_rd;
    @(posedge sclk) disable iff (cs_n)
      cnt_r == 5'h10 && rd_r && !cfg_q[CFG_4WIRE_BIT] |-> sdio_oe;
  endproperty
  a_oe_rd: assert property (p_oe_rd) else $error("no drive in read");
  property p_oe_wr;
    @(posedge sclk) disable iff (cs_n) cnt_r != 5'h00 && !rd_r |-> !sdio_oe;
  endproperty
  a_oe_wr: assert property (p_oe_wr) else $error("drive in write");
  property p_4w;
    @(posedge sclk) disable iff (cs_n) cfg_q[CFG_4WIRE_BIT] |-> !sdio_oe && sdo == sdio_o;
  endproperty
  a_4w: assert property (p_4w) else $error("drive in four-wire");
  c_soft: cover property (@(posedge clk) soft_rst_q);
  c_oe: cover property (@(posedge sclk) sdio_oe);
  c_load: cover property (@(posedge clk) $changed(wide_q) && !rst);
endmodule : bsp_port_chk
bind bsp_spi_port bsp_port_chk #(.NWIDE(NWIDE)) u_chk (.clk(clk), .rst(rst), .ce(ce),
  .load(load), .cs_n(cs_n), .sclk(sclk), .sdio_i(sdio_i), .sdio_o(sdio_o),
  .sdio_oe(sdio_oe), .sdo(sdo), .cfg_q(cfg_q), .bsel_q(bsel_q), .soft_rst_q(soft_rst_q),
  .wide_q(wide_q));
`default_nettype wire

// >>> bsp_host.sv
/*
  Host model of the serial link, 30 ns bit period, 45 ns on clocks 17 to 26.
  Reads the device answer on sdio, or on sdo in four-wire mode; sclk stands still between frames.
*/
`default_nettype none
module bsp_host (
  output logic cs_n,
  output logic sclk,
  output wire logic sdio_i,
  input wire logic sdio_o,
  input wire logic sdio_oe,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drv_r = 1'b0;
  logic lsb = 1'b0;
  logic four_w = 1'b0;
  // a short select pulse puts the port in a known idle state at start
  initial
  begin
    cs_n = 1'b0;
    sclk = 1'b0;
    #5 cs_n = 1'b1;
  end
  assign sdio_i = sdio_oe ? sdio_o : drv_r;
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [31:0] wd,
    input int n, output logic [31:0] q);
    int j;
    int b;
    q = '0;
    cs_n = 1'b0;
    for (int t = 0; t < 16 + 8 * n; t++)
    begin
      j = (t - 16) % 8;
      b = (t - 16) / 8;
      if (t == 0)
        drv_r = rd;
      else if (t < 16)
        drv_r = lsb ? a[t-1] : a[15-t];
      else if (rd)
        drv_r = ~drv_r;
      else
        drv_r = lsb ? wd[8*b+j] : wd[8*b+7-j];
      #15 sclk = 1'b1;
      if (t >= 16)
        q[8*b+(lsb ? j : 7-j)] = four_w ? sdo : sdio_i;
      #15 sclk = 1'b0;
      // longer low phase on clocks 17 to 26
      if (t >= 16 && t < 26)
        #15;
    end
    #15 cs_n = 1'b1;
    drv_r = ~drv_r;
    #30;
  endtask : xfer
endmodule : bsp_host
`default_nettype wire

// >>> beamformer_spi_register_port_tb.sv
/*
  Bench of the serial register port.
  Assumes bsp_host on the link and the bound checker.
*/
`default_nettype none
module beamformer_spi_register_port_tb;
  import bsp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic load = 1'b0;
  logic ce = 1'b1;
  wire logic cs_n, sclk, sdio_i, sdio_o, sdio_oe, sdo, soft_rst_q;
  wire logic [7:0] cfg_q, bsel_q;
  wire logic [63:0] wide_q;
  int err_total = 0;
  int tests_run = 0;
  always #10 clk = ~clk;
  bsp_spi_port u_dut (.clk(clk), .rst(rst), .ce(ce), .load(load), .cs_n(cs_n),
    .sclk(sclk), .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe(sdio_oe), .sdo(sdo),
    .cfg_q(cfg_q), .bsel_q(bsel_q), .soft_rst_q(soft_rst_q), .wide_q(wide_q));
  bsp_host u_host (.cs_n(cs_n), .sclk(sclk), .sdio_i(sdio_i), .sdio_o(sdio_o),
    .sdio_oe(sdio_oe), .sdo(sdo));
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [14:0] a, input logic [31:0] d, input int n);
    logic [31:0] q;
    u_host.xfer(1'b0, a, d, n, q);
    repeat (10) @(posedge clk);
  endtask : wr
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    logic [31:0] q;
    repeat (2) u_host.xfer(1'b1, a, 32'h0, 1, q);
    check($sformatf("read %0h", a), q[7:0], e);
  endtask : rd
  task automatic t_wide();
    wr(ADDR_BSEL, 8'h01, 1);
    wr(WIDE_BASE, 8'hA5, 1);
    wr(ADDR_BSEL, 8'h02, 1);
    wr(WIDE_BASE, 8'h3C, 1);
    check("bsel", bsel_q, 8'h02);
    rd(WIDE_BASE, 8'h3C);
    // a select of neither half must leave the wide register alone
    wr(ADDR_BSEL, 8'h03, 1);
    wr(WIDE_BASE + 15'h1, 8'h77, 1);
    rd(WIDE_BASE + 15'h1, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      check("staged", wide_q, 64'h0);
      @(posedge clk);
      #1 load = ~load;
      repeat (8) @(posedge clk);
    end
    check("wide", wide_q, 64'h3CA5);
  endtask : t_wide
  task automatic t_stream();
    logic [7:0] exp [6] = '{8'h33, 8'h22, 8'h11, 8'h44, 8'h55, 8'h66};
    logic [2:0] off [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    wr(SRAM_BASE + 15'h2, 32'h332211, 3);
    wr(ADDR_CFG, 8'h20, 1);
    check("cfg", cfg_q, 8'h20);
    wr(SRAM_BASE + 15'h4, 32'h665544, 3);
    for (int i = 0; i < 6; i++)
      rd(SRAM_BASE + 15'(off[i]), exp[i]);
  endtask : t_stream
  task automatic t_soft();
    wr(ADDR_CFG, 8'h80, 1);
    check("cfg", cfg_q, CFG_RST);
    check("wide", wide_q, 64'h0);
    rd(SRAM_BASE + 15'h2, 8'h11);
  endtask : t_soft
  task automatic t_lsb();
    wr(ADDR_CFG, 8'h40, 1);
    u_host.lsb = 1'b1;
    wr(ADDR_BSEL, 8'h01, 1);
    check("bsel", bsel_q, 8'h01);
    wr(ADDR_CFG, 8'h10, 1);
    u_host.lsb = 1'b0;
    u_host.four_w = 1'b1;
    check("cfg", cfg_q, 8'h10);
    rd(ADDR_BSEL, 8'h01);
    rd(15'h7FFF, 8'h00);
  endtask : t_lsb
  task automatic t_ce();
    @(posedge clk);
    #1 ce = 1'b0;
    wr(ADDR_BSEL, 8'h02, 1);
    check("frozen", bsel_q, 8'h01);
    #1 ce = 1'b1;
    repeat (10) @(posedge clk);
    check("resumed", bsel_q, 8'h02);
  endtask : t_ce
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    repeat (2) @(posedge clk);
    check("cfg", cfg_q, CFG_RST);
    check("wide", wide_q | 64'(bsel_q), 64'h0);
    check("soft", 64'(soft_rst_q), 64'h0);
    t_wide();
    t_stream();
    t_soft();
    t_lsb();
    t_ce();
    end_of_test();
  end
  initial
  begin
    #200000;
    err_total++;
    end_of_test();
  end
endmodule : beamformer_spi_register_port_tb
`default_nettype wire
